// ==== logic/ctrl_word_pkg.sv ====
// Constants and types shared by the control word bank
package ctrl_word_pkg;
	// Register geometry
	localparam int REG_W = 16;
	localparam logic [4:0] CTRL_REG_ADDR = 5'h00;
	localparam logic [4:0] BROADCAST_PHY_ADDR = 5'h00;
	localparam logic [15:0] REG_ZERO = 16'h0000;
	// Control word field positions
	localparam int AUTONEG_ON_POS = 12;
	localparam int LOW_POWER_POS = 11;
	localparam int HIGH_Z_POS = 10;
	localparam int RESTART_POS = 9;
	localparam int DUPLEX_POS = 8;
	localparam int COL_TEST_POS = 7;
	// Capability strap lanes
	localparam int CAP_FULL_POS = 1;
	localparam int CAP_HALF_POS = 0;
	// Management frame layout, header counted after the first start bit
	localparam logic [5:0] PREAMBLE_CNT = 6'h20;
	localparam logic [3:0] HEADER_LAST = 4'hC;
	localparam logic [3:0] TURN_LAST = 4'h1;
	localparam logic [3:0] DATA_LAST = 4'hF;
	localparam int HDR_START_POS = 12;
	localparam int HDR_OP_MSB = 11;
	localparam int HDR_OP_LSB = 10;
	localparam int HDR_PHY_MSB = 9;
	localparam int HDR_PHY_LSB = 5;
	localparam int HDR_REG_MSB = 4;
	localparam int HDR_REG_LSB = 0;
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [1:0] OP_WRITE = 2'h1;
	// Serial engine states
	typedef enum logic [1:0] {
		ST_PREAMBLE = 2'b00,
		ST_HEADER = 2'b01,
		ST_TURN = 2'b10,
		ST_DATA = 2'b11
	} mdio_state_type;
endpackage

// ==== logic/mgmt_if.sv ====
// Carrier between the serial engine and the control word store
`timescale 1ns/1ps
interface mgmt_if;
	logic wr_stb; // One-cycle write strobe
	logic [4:0] reg_addr; // Register address of the frame
	logic [15:0] wr_data; // Write data
	logic [15:0] rd_data; // Current control word image
	logic autoneg_on_bit;
	logic low_power_bit;
	logic high_z_bit;
	logic autoneg_restart_bit;
	logic duplex_bit;
	logic collision_selftest_bit;
	modport store (input wr_stb, reg_addr, wr_data, output rd_data, autoneg_on_bit, low_power_bit,
		high_z_bit, autoneg_restart_bit, duplex_bit, collision_selftest_bit);
	modport engine (output wr_stb, reg_addr, wr_data, input rd_data, autoneg_on_bit, low_power_bit,
		high_z_bit, autoneg_restart_bit, duplex_bit, collision_selftest_bit);
endinterface // mgmt_if

// ==== logic/mii_isolate_gate.sv ====
// Registered MII output stage with shared-bus release
`timescale 1ns/1ps
module mii_isolate_gate #(
	parameter int WIDTH = 8
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic isolate,
	input wire logic [WIDTH-1:0] core_out,
	output logic [WIDTH-1:0] pin_out,
	output logic pin_oe
);
	// Data and enable from flops so the pins never glitch
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			pin_out <= '0;
			pin_oe <= 1'b0;
		end else if (clk_en) begin
			pin_out <= core_out;
			pin_oe <= !isolate;
		end
	end
endmodule // mii_isolate_gate

// ==== logic/control_word_store.sv ====
// Storage and side effects of the control word
`timescale 1ns/1ps
module control_word_store (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic phoneline_mode_enable,
	input wire logic autoneg_ability_pin,
	input wire logic high_z_default_pin,
	input wire logic [1:0] capability_strap_pins,
	mgmt_if.store bus
);
	logic wr_hit; // Write addressed to this word
	logic autoneg_on_q, low_power_q, high_z_q, restart_q, duplex_q, collision_selftest_bit_q;

	// Highest mode the straps permit
	function automatic logic best_duplex(input logic [1:0] caps);
		return caps[ctrl_word_pkg::CAP_FULL_POS];
	endfunction

	// Whether the straps permit a duplex value
	function automatic logic duplex_allowed(input logic v, input logic [1:0] caps);
		return v ? caps[ctrl_word_pkg::CAP_FULL_POS] : caps[ctrl_word_pkg::CAP_HALF_POS];
	endfunction

	assign wr_hit = bus.wr_stb && (bus.reg_addr == ctrl_word_pkg::CTRL_REG_ADDR);

	// Read-write fields and the read-only negotiation enable; straps caught by the synchronous reset
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			autoneg_on_q <= autoneg_ability_pin;
			high_z_q <= high_z_default_pin;
			low_power_q <= 1'b0;
			collision_selftest_bit_q <= 1'b0;
		end else if (clk_en && wr_hit) begin
			// Negotiation enable is read-only, so writes skip it
			low_power_q <= bus.wr_data[ctrl_word_pkg::LOW_POWER_POS];
			high_z_q <= bus.wr_data[ctrl_word_pkg::HIGH_Z_POS];
			collision_selftest_bit_q <= bus.wr_data[ctrl_word_pkg::COL_TEST_POS];
		end
	end

	// Duplex: strap-limited, refused values leave the bit alone
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			duplex_q <= best_duplex(capability_strap_pins);
		end else if (clk_en && wr_hit &&
			duplex_allowed(bus.wr_data[ctrl_word_pkg::DUPLEX_POS], capability_strap_pins)) begin
			duplex_q <= bus.wr_data[ctrl_word_pkg::DUPLEX_POS];
		end
	end

	// Restart: one cycle high, then clears itself
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			restart_q <= 1'b0;
		end else if (clk_en) begin
			restart_q <= wr_hit && bus.wr_data[ctrl_word_pkg::RESTART_POS] && autoneg_on_q
				&& !phoneline_mode_enable;
		end
	end

	// Read image; reserved and out-of-scope bits stay zero
	always_comb begin
		bus.rd_data = ctrl_word_pkg::REG_ZERO;
		bus.rd_data[ctrl_word_pkg::AUTONEG_ON_POS] = autoneg_on_q;
		bus.rd_data[ctrl_word_pkg::LOW_POWER_POS] = low_power_q;
		bus.rd_data[ctrl_word_pkg::HIGH_Z_POS] = high_z_q;
		bus.rd_data[ctrl_word_pkg::RESTART_POS] = restart_q;
		bus.rd_data[ctrl_word_pkg::DUPLEX_POS] = duplex_q;
		bus.rd_data[ctrl_word_pkg::COL_TEST_POS] = collision_selftest_bit_q;
	end

	assign bus.autoneg_on_bit = autoneg_on_q;
	assign bus.low_power_bit = low_power_q;
	assign bus.high_z_bit = high_z_q;
	assign bus.autoneg_restart_bit = restart_q;
	assign bus.duplex_bit = duplex_q;
	assign bus.collision_selftest_bit = collision_selftest_bit_q;

	// Negotiation enable never follows a write
	AST_AUTONEG_RO: assert property (@(posedge sys_clk) disable iff (!resetn)
		wr_hit |=> $stable(autoneg_on_q))
		else $error("negotiation enable changed on a write");

	// Restart bit never holds two cycles
	AST_RESTART_SELF_CLEAR: assert property (@(posedge sys_clk) disable iff (!resetn)
		restart_q && clk_en |=> !restart_q)
		else $error("restart bit did not clear itself");

	// Refused duplex write keeps the old value
	AST_DUPLEX_REFUSED: assert property (@(posedge sys_clk) disable iff (!resetn)
		clk_en && wr_hit && !duplex_allowed(bus.wr_data[ctrl_word_pkg::DUPLEX_POS], capability_strap_pins)
		|=> $stable(duplex_q))
		else $error("duplex changed to a value the straps forbid");

	// Isolate comes out of reset at the strap level
	AST_HIGH_Z_DEFAULT: assert property (@(posedge sys_clk)
		!resetn |=> high_z_q == $past(high_z_default_pin))
		else $error("isolate default does not match strap");
endmodule // control_word_store

// ==== logic/phy_control_word_bank.sv ====
// Control word bank behind the serial management pins
`timescale 1ns/1ps
module phy_control_word_bank #(
	parameter int MII_OUT_W = 6 // Receive-side MII outputs other than collision
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic mdc,
	input wire logic mdio_in,
	output logic mdio_out,
	output logic mdio_oe,
	input wire logic [4:0] station_phy_address,
	input wire logic phoneline_mode_enable,
	input wire logic autoneg_ability_pin,
	input wire logic high_z_default_pin,
	input wire logic [1:0] capability_strap_pins,
	input wire logic low_power_pin,
	input wire logic high_z_pin,
	input wire logic negotiated_full,
	input wire logic tx_en,
	input wire logic line_collision,
	input wire logic [MII_OUT_W-1:0] core_mii_out,
	output logic [MII_OUT_W-1:0] mii_out,
	output logic col,
	output logic mii_oe,
	output logic low_power,
	output logic full_duplex,
	output logic autoneg_restart
);
	mgmt_if bus (); // Engine to store carrier

	// Serial engine state
	ctrl_word_pkg::mdio_state_type state_q; // Frame phase
	logic mdc_prev_q; // Last sampled management clock
	logic mdc_rise; // Rising edge of the management clock
	logic [5:0] ones_q; // Preamble ones seen, saturating
	logic [3:0] cnt_q; // Bit index inside a phase
	logic [12:0] hdr_q; // Start, opcode, addresses
	logic [12:0] hdr_d; // Header with the current bit
	logic [15:0] shift_q; // Read or write data shifter
	logic is_read_q; // Frame is a read
	logic wr_stb_q; // Write strobe to the store
	logic isolate; // Either isolate source
	logic col_raw; // Collision before the gate
	logic [MII_OUT_W:0] gate_out; // Collision plus data through the gate
	logic col_oe_unused_guard; // Shared enable from the gate

	// Opcode field of a header
	function automatic logic [1:0] hdr_op(input logic [12:0] h);
		return h[ctrl_word_pkg::HDR_OP_MSB:ctrl_word_pkg::HDR_OP_LSB];
	endfunction

	// Station address field of a header
	function automatic logic [4:0] hdr_phy(input logic [12:0] h);
		return h[ctrl_word_pkg::HDR_PHY_MSB:ctrl_word_pkg::HDR_PHY_LSB];
	endfunction

	// Register address field of a header
	function automatic logic [4:0] hdr_reg(input logic [12:0] h);
		return h[ctrl_word_pkg::HDR_REG_MSB:ctrl_word_pkg::HDR_REG_LSB];
	endfunction

	// Frame is for us: start, legal opcode, own or broadcast address
	function automatic logic frame_ok(input logic [12:0] h, input logic [4:0] own);
		return h[ctrl_word_pkg::HDR_START_POS]
			&& (hdr_op(h) == ctrl_word_pkg::OP_READ || hdr_op(h) == ctrl_word_pkg::OP_WRITE)
			&& (hdr_phy(h) == own || hdr_phy(h) == ctrl_word_pkg::BROADCAST_PHY_ADDR);
	endfunction

	// Management clock is synchronous to sys_clk, so a plain edge detect
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			mdc_prev_q <= 1'b0;
		end else if (clk_en) begin
			mdc_prev_q <= mdc;
		end
	end

	assign mdc_rise = mdc && !mdc_prev_q;

	// Header shift including the bit now on the line
	always_comb begin
		hdr_d = {hdr_q[11:0], mdio_in};
	end

	// Frame engine; deliberately ignores power-down and isolate
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			state_q <= ctrl_word_pkg::ST_PREAMBLE;
			ones_q <= '0;
			cnt_q <= '0;
			hdr_q <= '0;
			shift_q <= ctrl_word_pkg::REG_ZERO;
			is_read_q <= 1'b0;
			mdio_out <= 1'b0;
			mdio_oe <= 1'b0;
			wr_stb_q <= 1'b0;
		end else if (clk_en) begin
			wr_stb_q <= 1'b0;
			if (mdc_rise) begin
				unique case (state_q)
					ctrl_word_pkg::ST_PREAMBLE: begin
						// Need a full run of ones before the zero start bit
						if (mdio_in) begin
							if (ones_q != ctrl_word_pkg::PREAMBLE_CNT) begin
								ones_q <= ones_q + 6'h01;
							end
						end else if (ones_q == ctrl_word_pkg::PREAMBLE_CNT) begin
							state_q <= ctrl_word_pkg::ST_HEADER;
							cnt_q <= '0;
						end else begin
							ones_q <= '0;
						end
					end
					ctrl_word_pkg::ST_HEADER: begin
						hdr_q <= hdr_d;
						cnt_q <= cnt_q + 4'h1;
						if (cnt_q == ctrl_word_pkg::HEADER_LAST) begin
							ones_q <= '0;
							cnt_q <= '0;
							if (frame_ok(hdr_d, station_phy_address)) begin
								state_q <= ctrl_word_pkg::ST_TURN;
								is_read_q <= (hdr_op(hdr_d) == ctrl_word_pkg::OP_READ);
								// Unmapped addresses answer all zeros
								shift_q <= (hdr_reg(hdr_d) == ctrl_word_pkg::CTRL_REG_ADDR) ?
									bus.rd_data : ctrl_word_pkg::REG_ZERO;
							end else begin
								// Foreign frame: wait for the next preamble
								state_q <= ctrl_word_pkg::ST_PREAMBLE;
							end
						end
					end
					ctrl_word_pkg::ST_TURN: begin
						cnt_q <= cnt_q + 4'h1;
						if (is_read_q && cnt_q != ctrl_word_pkg::TURN_LAST) begin
							// Second turnaround bit is our driven zero
							mdio_oe <= 1'b1;
							mdio_out <= 1'b0;
						end
						if (cnt_q == ctrl_word_pkg::TURN_LAST) begin
							state_q <= ctrl_word_pkg::ST_DATA;
							cnt_q <= '0;
							if (is_read_q) begin
								mdio_out <= shift_q[15];
								shift_q <= {shift_q[14:0], 1'b0};
							end
						end
					end
					ctrl_word_pkg::ST_DATA: begin
						cnt_q <= cnt_q + 4'h1;
						if (is_read_q) begin
							if (cnt_q == ctrl_word_pkg::DATA_LAST) begin
								mdio_oe <= 1'b0;
								mdio_out <= 1'b0;
							end else begin
								mdio_out <= shift_q[15];
								shift_q <= {shift_q[14:0], 1'b0};
							end
						end else begin
							// Write data arrives most significant bit first
							shift_q <= {shift_q[14:0], mdio_in};
							if (cnt_q == ctrl_word_pkg::DATA_LAST) begin
								wr_stb_q <= 1'b1;
							end
						end
						if (cnt_q == ctrl_word_pkg::DATA_LAST) begin
							state_q <= ctrl_word_pkg::ST_PREAMBLE;
							cnt_q <= '0;
						end
					end
				endcase
			end
		end
	end

	// Store sees the shifter the same cycle the strobe is high
	assign bus.wr_stb = wr_stb_q;
	assign bus.reg_addr = hdr_reg(hdr_q);
	assign bus.wr_data = shift_q;

	control_word_store u_store (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.clk_en(clk_en),
		.phoneline_mode_enable(phoneline_mode_enable),
		.autoneg_ability_pin(autoneg_ability_pin),
		.high_z_default_pin(high_z_default_pin),
		.capability_strap_pins(capability_strap_pins),
		.bus(bus)
	);

	// Restart pulse comes straight from the self-clearing bit
	assign autoneg_restart = bus.autoneg_restart_bit;

	// Low power from either source; shuts the datapath, not this bank
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			low_power <= 1'b0;
		end else if (clk_en) begin
			low_power <= bus.low_power_bit || low_power_pin;
		end
	end

	// Effective duplex; phoneline is always half duplex
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			full_duplex <= 1'b0;
		end else if (clk_en) begin
			if (phoneline_mode_enable) begin
				full_duplex <= 1'b0;
			end else if (bus.autoneg_on_bit) begin
				full_duplex <= negotiated_full;
			end else begin
				full_duplex <= bus.duplex_bit;
			end
		end
	end

	// Collision test echo, independent of duplex
	assign col_raw = line_collision
		|| (bus.collision_selftest_bit && !phoneline_mode_enable && tx_en);
	assign isolate = bus.high_z_bit || high_z_pin;

	// One gate for collision and data so they release together
	mii_isolate_gate #(
		.WIDTH(MII_OUT_W + 1)
	) u_gate (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.clk_en(clk_en),
		.isolate(isolate),
		.core_out({col_raw, core_mii_out}),
		.pin_out(gate_out),
		.pin_oe(col_oe_unused_guard)
	);

	assign col = gate_out[MII_OUT_W];
	assign mii_out = gate_out[MII_OUT_W-1:0];
	assign mii_oe = col_oe_unused_guard;

	// Power-down follows the bit within one cycle
	AST_LOW_POWER_BIT: assert property (@(posedge sys_clk) disable iff (!resetn)
		clk_en && bus.low_power_bit |=> low_power)
		else $error("low-power bit did not reach the output");

	// Power-down pin has the same effect
	AST_LOW_POWER_PIN: assert property (@(posedge sys_clk) disable iff (!resetn)
		clk_en && low_power_pin |=> low_power)
		else $error("low-power pin did not reach the output");

	// Manual duplex when negotiation is off
	AST_MANUAL_DUPLEX: assert property (@(posedge sys_clk) disable iff (!resetn)
		clk_en && !phoneline_mode_enable && !bus.autoneg_on_bit |=> full_duplex == $past(bus.duplex_bit))
		else $error("duplex does not follow the manual setting");

	// Negotiated duplex overrides the bit
	AST_NEGOTIATED_DUPLEX: assert property (@(posedge sys_clk) disable iff (!resetn)
		clk_en && !phoneline_mode_enable && bus.autoneg_on_bit |=> full_duplex == $past(negotiated_full))
		else $error("duplex bit leaked through while negotiating");

	// Phoneline mode stays half duplex
	AST_PHONELINE_HALF: assert property (@(posedge sys_clk) disable iff (!resetn)
		clk_en && phoneline_mode_enable |=> !full_duplex)
		else $error("full duplex in phoneline mode");

	// Collision echo of transmit enable
	AST_COL_TEST: assert property (@(posedge sys_clk) disable iff (!resetn)
		clk_en && bus.collision_selftest_bit && !phoneline_mode_enable && tx_en |=> col)
		else $error("collision test did not echo transmit enable");

	// Isolation releases all MII outputs
	AST_ISOLATE: assert property (@(posedge sys_clk) disable iff (!resetn)
		clk_en && (bus.high_z_bit || high_z_pin) |=> !mii_oe)
		else $error("MII outputs driven while isolated");

	// Restart only when negotiation is on
	AST_RESTART_GATED: assert property (@(posedge sys_clk) disable iff (!resetn)
		autoneg_restart |-> $past(bus.autoneg_on_bit) && !$past(phoneline_mode_enable))
		else $error("restart issued without negotiation enabled");

	// Read turnaround drives zero first
	AST_TURN_ZERO: assert property (@(posedge sys_clk) disable iff (!resetn)
		$rose(mdio_oe) |-> !mdio_out ##1 mdio_oe)
		else $error("turnaround bit not driven low");

	// Broadcast header is accepted
	AST_BROADCAST: assert property (@(posedge sys_clk) disable iff (!resetn)
		clk_en && mdc_rise && state_q == ctrl_word_pkg::ST_HEADER && cnt_q == ctrl_word_pkg::HEADER_LAST
		&& hdr_d[ctrl_word_pkg::HDR_START_POS] && hdr_phy(hdr_d) == ctrl_word_pkg::BROADCAST_PHY_ADDR
		&& (hdr_op(hdr_d) == ctrl_word_pkg::OP_READ || hdr_op(hdr_d) == ctrl_word_pkg::OP_WRITE)
		|=> state_q == ctrl_word_pkg::ST_TURN)
		else $error("broadcast frame ignored");

	// Reserved bits 6:0 always read zero
	AST_RESERVED_ZERO: assert property (@(posedge sys_clk) disable iff (!resetn)
		bus.rd_data[6:0] == 7'h00)
		else $error("reserved bits not zero");

	// Read answers even while powered down or isolated
	AST_READ_ANSWER: assert property (@(posedge sys_clk) disable iff (!resetn)
		clk_en && mdc_rise && state_q == ctrl_word_pkg::ST_TURN && is_read_q
		&& cnt_q != ctrl_word_pkg::TURN_LAST |=> mdio_oe && !mdio_out)
		else $error("read frame not answered");

	// Isolate pin alone releases the MII outputs
	AST_ISOLATE_PIN: assert property (@(posedge sys_clk) disable iff (!resetn)
		clk_en && high_z_pin |=> !mii_oe)
		else $error("isolate pin did not release the MII outputs");

	// Outputs come back once neither isolate source is set
	AST_MII_DRIVEN: assert property (@(posedge sys_clk) disable iff (!resetn)
		clk_en && !bus.high_z_bit && !high_z_pin |=> mii_oe)
		else $error("MII outputs released without isolation");

	// Accepted restart write always raises the pulse
	AST_RESTART_PULSE: assert property (@(posedge sys_clk) disable iff (!resetn)
		clk_en && bus.wr_stb && bus.reg_addr == ctrl_word_pkg::CTRL_REG_ADDR
		&& bus.wr_data[ctrl_word_pkg::RESTART_POS] && bus.autoneg_on_bit && !phoneline_mode_enable
		|=> autoneg_restart)
		else $error("restart write did not raise the pulse");

	// Frame for another station is dropped at the header end
	AST_FOREIGN_DROPPED: assert property (@(posedge sys_clk) disable iff (!resetn)
		clk_en && mdc_rise && state_q == ctrl_word_pkg::ST_HEADER && cnt_q == ctrl_word_pkg::HEADER_LAST
		&& hdr_phy(hdr_d) != station_phy_address && hdr_phy(hdr_d) != ctrl_word_pkg::BROADCAST_PHY_ADDR
		|=> state_q == ctrl_word_pkg::ST_PREAMBLE)
		else $error("frame for another station accepted");

	// Enable low holds every output; a freeze must not leak a change
	AST_FREEZE: assert property (@(posedge sys_clk) disable iff (!resetn)
		!clk_en |=> $stable(low_power) && $stable(mii_oe) && $stable(full_duplex) && $stable(state_q))
		else $error("state moved while the clock enable was low");
endmodule // phy_control_word_bank

// ==== verif/mgmt_host_model.sv ====
// Station manager model that drives the serial management pins
`timescale 1ns/1ps
module mgmt_host_model (
	input wire logic sys_clk,
	input wire logic mdio_out,
	input wire logic mdio_oe,
	output logic mdc,
	output logic mdio_wire
);
	logic host_oe; // High while the host drives the data line
	logic host_bit; // Level the host drives
	logic ta_seen; // Second turnaround bit of the last frame
	logic clash = 1'h0; // Both ends drove the line at once
	int half_cycles = 2; // Clock half period in sys_clk cycles, raised for a slow host

	// Shared line with a pull-up: released line reads one, never the last value
	assign mdio_wire = host_oe ? host_bit : (mdio_oe ? mdio_out : 1'h1);

	// Idle: clock parked low, line released
	initial begin
		mdc = 1'h0;
		host_oe = 1'h0;
		host_bit = 1'h1;
	end

	// Contention watch, the device must only drive while the host is off
	always @(posedge sys_clk) begin
		if (host_oe && mdio_oe === 1'h1) begin
			clash <= 1'h1;
		end
	end

	// Wait n edges, then step just past the edge
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	// One whole frame with its own preamble, sixteen data bits MSB first
	task automatic xfer(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] regad,
		input logic [15:0] wdata, output logic [15:0] rdata);
		logic [63:0] frame;
		logic [63:0] seen;
		frame = {32'hFFFFFFFF, 2'h1, op, phy, regad, 2'h2, wdata};
		for (int i = 0; i < 64; i++) begin
			// Read: line handed over from the turnaround on
			host_oe = !(op == 2'h2 && i >= 46);
			host_bit = frame[63-i];
			tick(half_cycles);
			// Sampled just before the rising clock, where the device output stands
			seen[63-i] = mdio_wire;
			mdc = 1'h1;
			tick(half_cycles);
			mdc = 1'h0;
		end
		host_oe = 1'h0;
		rdata = seen[15:0];
		ta_seen = seen[16];
		// Let an edge pass so the next frame never re-drives in this step
		tick(1);
	endtask
endmodule // mgmt_host_model

// ==== verif/tb.sv ====
// Self-checking bench of the control word bank
`timescale 1ns/1ps
module tb;
	logic sys_clk = 1'h0;
	logic resetn = 1'h0;
	logic clk_en = 1'h1; // Left running except for the freeze check at the end
	logic mdc;
	logic mdio_wire;
	logic mdio_out;
	logic mdio_oe;
	logic [4:0] own_addr = 5'h15; // Own station address
	logic phone = 1'h0;
	logic an_pin = 1'h0;
	logic hz_pin_strap = 1'h0;
	logic [1:0] cap = 2'h3;
	logic lp_pin = 1'h0;
	logic hz_pin = 1'h0;
	logic neg_full = 1'h0;
	logic tx_en = 1'h0;
	logic line_col = 1'h0;
	logic [5:0] core_out = 6'h00;
	logic [5:0] mii_out;
	logic col;
	logic mii_oe;
	logic low_power;
	logic full_duplex;
	logic autoneg_restart;
	int err_total = 0;
	int num_checks = 0;
	int pulse_cnt = 0; // Cycles with the restart pulse high
	logic m_an, m_lp, m_iso, m_dup, m_collision_selftest_bit; // Reference copy of the stored fields
	logic [15:0] rd;

	// Clock, 100 ns period
	always #50 sys_clk = ~sys_clk;

	// Restart pulse width counter
	always @(posedge sys_clk) begin
		if (autoneg_restart === 1'h1) begin
			pulse_cnt++;
		end
	end

	phy_control_word_bank phy_control_word_bank_inst (.sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en),
		.mdc(mdc), .mdio_in(mdio_wire), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .station_phy_address(own_addr),
		.phoneline_mode_enable(phone), .autoneg_ability_pin(an_pin), .high_z_default_pin(hz_pin_strap),
		.capability_strap_pins(cap), .low_power_pin(lp_pin), .high_z_pin(hz_pin), .negotiated_full(neg_full),
		.tx_en(tx_en), .line_collision(line_col), .core_mii_out(core_out), .mii_out(mii_out), .col(col),
		.mii_oe(mii_oe), .low_power(low_power), .full_duplex(full_duplex), .autoneg_restart(autoneg_restart));

	mgmt_host_model mgmt_host_model_inst (.sys_clk(sys_clk), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
		.mdc(mdc), .mdio_wire(mdio_wire));

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	// Word compare
	task automatic check_word(input string what, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Single pin compare
	task automatic check_pin(input string what, input logic exp, input logic got);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("FAIL %s expected %b seen %b", what, exp, got);
		end
	endtask

	// Expected read image, reserved and self-clearing bits at zero
	function automatic logic [15:0] exp_word();
		return {3'h0, m_an, m_lp, m_iso, 1'h0, m_dup, m_collision_selftest_bit, 7'h00};
	endfunction

	// Reset with given straps, held ten cycles
	task automatic do_reset(input logic an, input logic hz, input logic [1:0] c);
		resetn = 1'h0;
		an_pin = an;
		hz_pin_strap = hz;
		cap = c;
		tick(10);
		resetn = 1'h1;
		m_an = an;
		m_iso = hz;
		m_dup = c[1];
		m_lp = 1'h0;
		m_collision_selftest_bit = 1'h0;
	endtask

	// Write the control word and check the restart pulse it causes
	task automatic wr(input logic [15:0] d, input logic [4:0] phy);
		logic [15:0] unused;
		logic exp_rs;
		exp_rs = m_an && d[9] && !phone;
		pulse_cnt = 0;
		mgmt_host_model_inst.xfer(ctrl_word_pkg::OP_WRITE, phy, ctrl_word_pkg::CTRL_REG_ADDR, d, unused);
		tick(4);
		check_word("restart pulse cycles", 16'(exp_rs), 16'(pulse_cnt));
		m_lp = d[11];
		m_iso = d[10];
		m_collision_selftest_bit = d[7];
		// Duplex only takes a value the straps allow
		if (d[8] ? cap[1] : cap[0]) begin
			m_dup = d[8];
		end
	endtask

	// Read the control word and compare with the reference copy
	task automatic rd_chk(input logic [4:0] phy);
		mgmt_host_model_inst.xfer(ctrl_word_pkg::OP_READ, phy, ctrl_word_pkg::CTRL_REG_ADDR, 16'h0000, rd);
		check_word("turnaround bit", 16'h0000, 16'(mgmt_host_model_inst.ta_seen));
		check_word("control word", exp_word(), rd);
	endtask

	// Random pin levels, then effects on the MII side
	task automatic check_pins();
		logic oe;
		for (int k = 0; k < 3; k++) begin
			{phone, lp_pin, hz_pin, neg_full, tx_en, line_col} = 6'($urandom);
			core_out = 6'($urandom);
			tick(2);
			oe = !(m_iso || hz_pin);
			check_pin("low power", m_lp | lp_pin, low_power);
			check_pin("mii enable", oe, mii_oe);
			check_pin("full duplex", !phone && (m_an ? neg_full : m_dup), full_duplex);
			if (oe) begin
				check_pin("collision", line_col | (tx_en & m_collision_selftest_bit & !phone), col);
				check_word("mii out", 16'(core_out), 16'(mii_out));
			end
		end
	endtask

	// Verdict, the single end of the run
	task automatic results();
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Watchdog, well above the expected run length
	initial begin
		repeat (80000) @(posedge sys_clk);
		err_total++;
		$display("FAIL watchdog expected finish seen hang");
		results();
	end

	// Main sequence
	initial begin
		void'($urandom(54));
		for (int r = 0; r < 3; r++) begin
			// First reset random straps, then two fixed corners
			if (r == 0) begin
				do_reset(1'($urandom), 1'($urandom), 2'($urandom));
			end else begin
				do_reset(r == 2, r == 1, (r == 2) ? 2'h3 : 2'h1);
			end
			rd_chk(own_addr);
			rd_chk(ctrl_word_pkg::BROADCAST_PHY_ADDR);
			check_pins();
			phone = 1'h1;
			wr(exp_word() | 16'h0200, own_addr);
			phone = 1'h0;
			wr(exp_word() | 16'h0200, own_addr);
			rd_chk(own_addr);
		end
		// Random writes, random straps, prompt and slow host
		for (int i = 0; i < 12; i++) begin
			cap = 2'($urandom);
			mgmt_host_model_inst.half_cycles = (i % 3 == 0) ? 4 : 2;
			wr(16'($urandom), ($urandom % 2) ? own_addr : 5'h00);
			rd_chk(own_addr);
			check_pins();
		end
		// Frame to another station is ignored, no drive on the line
		mgmt_host_model_inst.xfer(ctrl_word_pkg::OP_WRITE, 5'h0A, 5'h00, 16'h0C80, rd);
		mgmt_host_model_inst.xfer(ctrl_word_pkg::OP_READ, 5'h0A, 5'h00, 16'h0000, rd);
		check_word("foreign read", 16'hFFFF, rd);
		// Other register address reads zero, writes do not reach the word
		mgmt_host_model_inst.xfer(ctrl_word_pkg::OP_WRITE, own_addr, 5'h01, 16'hFFFF, rd);
		mgmt_host_model_inst.xfer(ctrl_word_pkg::OP_READ, own_addr, 5'h01, 16'h0000, rd);
		check_word("other register", 16'h0000, rd);
		rd_chk(own_addr);
		// Freeze: pins move while the enable is low, outputs must hold
		rd = {12'h000, low_power, mii_oe, full_duplex, col};
		clk_en = 1'h0;
		{lp_pin, hz_pin, neg_full, line_col} = ~{lp_pin, hz_pin, neg_full, line_col};
		tick(3);
		check_word("frozen outputs", rd, {12'h000, low_power, mii_oe, full_duplex, col});
		clk_en = 1'h1;
		check_pin("line contention", 1'h0, mgmt_host_model_inst.clash);
		results();
	end
endmodule // tb
